//--- dv/tap_model.sv
// Purpose: test-port controller model driving tck, the state flags and tdi
// Assumes: the device answers on tdo after each rising tck
// Notes: tck stands still between frames; tdi shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module tap_model
  import bscan_pkg::*;
(
  output logic tck,
  output tap_ctl_t tap,
  output logic tdi,
  input wire logic tdo
);
  // ----------------------------------------------------------------
  // state flag codes, one-hot in the carrier's bit order
  // ----------------------------------------------------------------
  localparam tap_ctl_t F_RESET = tap_ctl_t'(8'h80);
  localparam tap_ctl_t F_IDLE = tap_ctl_t'(8'h40);
  localparam realtime HALF = 7.5;

  initial
  begin
    tck = 1'b0;
    tap = F_IDLE;
    tdi = 1'b0;
  end

  // one tck period; flags change only while tck is low, tdo read just before the fall
  task automatic step(input tap_ctl_t f, input logic d, output logic o);
    tap = f;
    tdi = d;
    #HALF;
    tck = 1'b1;
    #HALF;
    o = tdo;
    tck = 1'b0;
  endtask

  task automatic tlr(input int n);
    logic o;
    repeat (n) step(F_RESET, ~tdi, o);
    #HALF;
    tap = F_IDLE;
  endtask

  task automatic idle(input int n);
    logic o;
    repeat (n) step(F_IDLE, ~tdi, o);
  endtask

  // capture, n shifts lsb first, update; dout holds the bits seen on tdo
  task automatic scan(input logic ir, input int n, input logic [17:0] din,
                      output logic [17:0] dout);
    logic o;
    dout = '0;
    step(tap_ctl_t'(ir ? 8'h04 : 8'h20), ~tdi, o);
    dout[0] = o;
    for (int k = 1; k <= n; k++)
    begin
      step(tap_ctl_t'(ir ? 8'h02 : 8'h10), din[k-1], o);
      if (k < n)
      begin
        dout[k] = o;
      end
    end
    step(tap_ctl_t'(ir ? 8'h01 : 8'h08), ~din[n-1], o);
    #HALF;
    tap = F_IDLE;
  endtask
endmodule
`default_nettype wire

//--- dv/test_boundary_scan_data_registers.sv
// Purpose: self-checking bench for the boundary-scan data registers
// Assumes: the controller model supplies tck frames; pins are set once at time 0
// Notes: port checks wait 8 clk so the tck-to-clk crossing has settled
`timescale 1ns/1ps
`default_nettype none
module test_boundary_scan_data_registers
  import bscan_pkg::*;
;
  logic clk;
  logic rst_n;
  logic tck;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  tap_ctl_t tap;
  pins_t pins_in;
  logic [7:0] a_out;
  logic a_oe;
  logic [7:0] b_out;
  logic b_oe;
  int mismatches = 0;
  int compares = 0;
  logic [17:0] o;

  // ----------------------------------------------------------------
  // expectations: {a_oe, b_oe, a_out, b_out} for normal, test, float
  // ----------------------------------------------------------------
  localparam logic [17:0] P = 18'h0665A;
  localparam logic [17:0] ALL = 18'h3FFFF;
  localparam logic [17:0] EXP [3] = '{18'h1003C, 18'h25A00, 18'h00000};
  localparam logic [17:0] MSK [3] = '{18'h300FF, 18'h3FF00, 18'h30000};
  logic [7:0] ops [18] = '{8'h00, 8'h80, 8'h03, 8'h07, 8'h09, 8'h0B, 8'h0D, 8'h0F, 8'h06,
                          8'h01, 8'h04, 8'h05, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h7F, 8'hFF};
  int cls [18] = '{1, 1, 1, 1, 1, 1, 1, 1, 2, 0, 0, 0, 0, 0, 0, 0, 0, 0};

  bscan_data_regs bscan_data_regs_i (.clk(clk), .rst_n(rst_n), .tck(tck), .tdi(tdi),
    .tap(tap), .tdo(tdo), .tdo_oe(tdo_oe), .pins_in(pins_in), .a_out(a_out),
    .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe));

  tap_model tap_model_i (.tck(tck), .tap(tap), .tdi(tdi), .tdo(tdo));

  always #2 clk = ~clk;

  // ----------------------------------------------------------------
  // shared checks and transfers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got,
                     input logic [17:0] msk);
    compares++;
    if ((got & msk) !== (exp & msk))
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp & msk, got & msk);
    end
  endtask

  task automatic ir(input logic [7:0] op);
    tap_model_i.scan(1'b1, 8, {10'h000, op}, o);
    chk("ir_capture", 18'h00081, o, ALL);
    chk("tdo_oe", 18'h00000, {17'h00000, tdo_oe}, ALL);
  endtask

  task automatic dr(input int n, input logic [17:0] din, input logic [17:0] exp);
    tap_model_i.scan(1'b0, n, din, o);
    chk("dr_capture", exp, o, ALL);
  endtask

  // crossing to clk takes a few cycles, so the ports are read later
  task automatic ports(input logic [17:0] exp, input logic [17:0] msk);
    repeat (8) @(negedge clk);
    chk("ports", exp, {a_oe, b_oe, a_out, b_out}, msk);
  endtask

  task automatic give_verdict;
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    pins_in = '{dir: 1'b1, en_n: 1'b0, a: 8'h3C, b: 8'hC3};
    fork
      tap_model_i.tlr(3);
      repeat (10) @(negedge clk);
    join
    @(negedge clk);
    rst_n = 1'b1;
    ports(EXP[0], MSK[0]);
    dr(2, 18'h00001, 18'h00002);
    ir({1'b0, OP_SELECTOR_SCAN_NORMAL});
    dr(2, 18'h00001, 18'h00002);
    dr(2, 18'h00000, 18'h00001);
    tap_model_i.tlr(1);
    ir({1'b0, OP_SELECTOR_SCAN_NORMAL});
    dr(2, 18'h00000, 18'h00002);
    ir({1'b0, OP_SAMPLE});
    dr(18, P, 18'h23C3C);
    ports(EXP[0], MSK[0]);
    for (int i = 0; i < 18; i++)
    begin
      ir(ops[i]);
      ports(EXP[cls[i]], MSK[cls[i]]);
    end
    ir({1'b0, OP_READ_CHAIN_NORMAL});
    dr(18, P, P);
    ir({1'b0, OP_CELL_SELF_CHECK});
    dr(18, P, ~P & ALL);
    tap_model_i.tlr(2);
    ir({1'b0, OP_READ_CHAIN_NORMAL});
    dr(18, P, P);
    ir({1'b0, OP_TOGGLE_OUTPUTS});
    dr(1, 18'h00000, 18'h00000);
    ports(EXP[1], MSK[1]);
    tap_model_i.idle(1);
    ports(18'h2A500, MSK[1]);
    ir({1'b0, OP_SELECTOR_SCAN_NORMAL});
    dr(2, 18'h00000, 18'h00002);
    ir({1'b0, OP_READ_CHAIN_NORMAL});
    dr(18, P, 18'h066A5);
    ir({1'b0, OP_RUN_SELECTED_TEST});
    tap_model_i.idle(1);
    ports(18'h2A500, MSK[1]);
    ir({1'b0, OP_READ_CHAIN_NORMAL});
    dr(18, P, 18'h0C3A5);
    give_verdict();
  end

  // hang guard: the sequence needs well under 20 us
  initial
  begin
    #100us;
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire

//--- hw/bscan_data_regs.sv
// Purpose: boundary chain, run-test selector, bypass stage and instruction
//   decode, plus the functional transceiver path they steer
// Assumes: tap flags are one-hot and come from logic on tck; pins are async
// Notes: shadow updates happen on the rising tck edge that leaves update, and on run-test idle edges for the toggle and selected-test runs
`timescale 1ns/1ps
`default_nettype none
module bscan_data_regs
  import bscan_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tdi,
  input wire tap_ctl_t tap,
  output logic tdo,
  output logic tdo_oe,
  input wire pins_t pins_in,
  output logic [7:0] a_out,
  output logic a_oe,
  output logic [7:0] b_out,
  output logic b_oe
);

  // ----------------------------------------------------------------
  // state of both domains
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CHAIN_W-1:0] chain;
    logic [CHAIN_W-1:0] shadow;
    logic [SEL_W-1:0] sel_shift;
    logic [SEL_W-1:0] sel;
    logic bypass;
    logic [IR_W-1:0] ir_shift;
    logic [IR_W-1:0] instr;
    logic tdo;
    logic tdo_oe;
  } scan_st_t;

  typedef struct packed {
    logic [7:0] a_out;
    logic a_oe;
    logic [7:0] b_out;
    logic b_oe;
  } func_st_t;

  scan_st_t sc_q;
  scan_st_t sc_d;
  func_st_t fn_q;
  func_st_t fn_d;
  pins_t pins_tck;
  pins_t pins_clk;
  xfer_t to_func;
  xfer_t func_view;
  decode_t dec;
  decode_t dec_next;

  // ----------------------------------------------------------------
  // feedback shifts for pattern and signature work
  // ----------------------------------------------------------------
  function automatic logic [15:0] step16(input logic [15:0] v);
    return {v[14:0], ^(v & TAPS16)};
  endfunction

  function automatic logic [7:0] step8(input logic [7:0] v);
    return {v[6:0], ^(v & TAPS8)};
  endfunction

  // ----------------------------------------------------------------
  // pin crossings
  // ----------------------------------------------------------------
  // pins reach the scan side through two tck flops before capture
  sync_bits #(.W($bits(pins_t))) u_pins_tck (
    .clk(tck),
    .rst_n(rst_n),
    .d(pins_in),
    .q(pins_tck)
  );

  // and the functional side through two clk flops
  sync_bits #(.W($bits(pins_t))) u_pins_clk (
    .clk(clk),
    .rst_n(rst_n),
    .d(pins_in),
    .q(pins_clk)
  );

  // mode and shadow word cross to the functional side as one word
  word_xfer #(.W($bits(xfer_t))) u_xfer (
    .src_clk(tck),
    .dst_clk(clk),
    .rst_n(rst_n),
    .src_data(to_func),
    .dst_data(func_view)
  );

  assign dec = decode_op(sc_q.instr);
  // next state feeds the crossing: tck may stop right after update, so the
  // word is latched at the very edge that changes it, not at a later one
  assign dec_next = decode_op(sc_d.instr);
  assign to_func = '{mode: dec_next.mode, cells: sc_d.shadow};

  // ----------------------------------------------------------------
  // scan side, test clock
  // ----------------------------------------------------------------
  // values seen at the input cells and at the core outputs
  logic dir_eff;
  logic [7:0] in_pins;
  logic [7:0] core_out;

  always_comb
  begin
    // test modes drive direction from the cell, normal mode from the pin
    dir_eff = (dec.mode == MODE_TEST) ? sc_q.shadow[DIR_BIT] : pins_tck.dir;
    in_pins = dir_eff ? pins_tck.a : pins_tck.b;
    // core is a straight buffer: it sees pins in normal, input cells in test
    core_out = (dec.mode == MODE_TEST) ? sc_q.shadow[IN_MSB:IN_LSB] : in_pins;
  end

  // one process computes every scan-side next value
  always_comb
  begin
    sc_d = sc_q;
    if (tap.reset)
    begin
      // chain and shadow are left alone here on purpose
      sc_d.ir_shift = IR_RESET;
      sc_d.instr = IR_RESET;
      sc_d.sel_shift = SEL_RESET;
      sc_d.sel = SEL_RESET;
    end
    else
    begin
      // instruction path
      if (tap.capture_ir)
        sc_d.ir_shift = IR_CAPTURE;
      if (tap.shift_ir)
        sc_d.ir_shift = {tdi, sc_q.ir_shift[IR_W-1:1]};
      if (tap.update_ir)
        sc_d.instr = sc_q.ir_shift;
      // capture into the selected data register
      if (tap.capture_dr)
      begin
        unique case (dec.dreg)
          DR_BYPASS: sc_d.bypass = 1'b0;
          DR_SELECTOR: sc_d.sel_shift = sc_q.sel_shift;
          DR_CHAIN:
          begin
            unique case (dec.cap)
              CAP_PINS: sc_d.chain = {pins_tck.dir, pins_tck.en_n, in_pins, core_out};
              CAP_INVERT: sc_d.chain = ~sc_q.shadow;
              CAP_KEEP: sc_d.chain = sc_q.chain;
            endcase
          end
        endcase
      end
      // serial shift, least significant cell leaves first
      if (tap.shift_dr)
      begin
        unique case (dec.dreg)
          DR_BYPASS: sc_d.bypass = tdi;
          DR_SELECTOR: sc_d.sel_shift = {tdi, sc_q.sel_shift[1]};
          DR_CHAIN: sc_d.chain = {tdi, sc_q.chain[CHAIN_W-1:1]};
        endcase
      end
      // shifted values reach the shadows here, and also through the run-test idle operations below
      if (tap.update_dr)
      begin
        unique case (dec.dreg)
          DR_SELECTOR: sc_d.sel = sc_q.sel_shift;
          DR_CHAIN: sc_d.shadow = sc_q.chain;
          DR_BYPASS: sc_d.bypass = sc_q.bypass;
        endcase
      end
      // run-test idle operations; control cells 17..16 never take part
      if (tap.idle && dec.run == RUN_TOGGLE)
      begin
        sc_d.chain[OUT_MSB:0] = ~sc_q.chain[OUT_MSB:0];
        sc_d.shadow[OUT_MSB:0] = ~sc_q.chain[OUT_MSB:0];
      end
      if (tap.idle && dec.run == RUN_SELECTED)
      begin
        unique case (sc_q.sel)
          SEL_SAMPLE_IN_TOGGLE_OUT:
            sc_d.chain[IN_MSB:0] = {in_pins, ~sc_q.chain[OUT_MSB:0]};
          SEL_PATTERN_GENERATE:
            sc_d.chain[IN_MSB:0] = step16(sc_q.chain[IN_MSB:0]);
          SEL_SIGNATURE_COMPRESS:
            sc_d.chain[IN_MSB:0] = step16(sc_q.chain[IN_MSB:0]) ^ {in_pins, 8'h00};
          SEL_BOTH_EIGHT:
            sc_d.chain[IN_MSB:0] = {step8(sc_q.chain[IN_MSB:IN_LSB]) ^ in_pins,
                                    step8(sc_q.chain[OUT_MSB:0])};
        endcase
        // signature leaves output shadows constant; others refresh all sixteen
        sc_d.shadow[IN_MSB:IN_LSB] = sc_d.chain[IN_MSB:IN_LSB];
        if (sc_q.sel != SEL_SIGNATURE_COMPRESS)
          sc_d.shadow[OUT_MSB:0] = sc_d.chain[OUT_MSB:0];
      end
    end
    // serial output follows the new lsb of whichever register is in the path
    sc_d.tdo_oe = !tap.reset && (tap.capture_dr || tap.shift_dr ||
                  tap.capture_ir || tap.shift_ir);
    if (tap.capture_ir || tap.shift_ir)
      sc_d.tdo = sc_d.ir_shift[0];
    else
    begin
      unique case (dec.dreg)
        DR_BYPASS: sc_d.tdo = sc_d.bypass;
        DR_SELECTOR: sc_d.tdo = sc_d.sel_shift[0];
        DR_CHAIN: sc_d.tdo = sc_d.chain[0];
      endcase
    end
  end

  // power-up state; the chain starts cleared only because a flop must
  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sc_q <= '0;
      sc_q.ir_shift <= IR_RESET;
      sc_q.instr <= IR_RESET;
      sc_q.sel_shift <= SEL_RESET;
      sc_q.sel <= SEL_RESET;
    end
    else
      sc_q <= sc_d;
  end

  assign tdo = sc_q.tdo;
  assign tdo_oe = sc_q.tdo_oe;

  // ----------------------------------------------------------------
  // functional side, system clock
  // ----------------------------------------------------------------
  // direction picks which port receives; float mode keeps logic but no drive
  always_comb
  begin
    logic dir;
    logic en;
    logic [7:0] data;
    dir = 1'b0;
    en = 1'b0;
    data = 8'h00;
    fn_d = fn_q;
    if (func_view.mode == MODE_TEST)
    begin
      dir = func_view.cells[DIR_BIT];
      en = !func_view.cells[EN_BIT];
      data = func_view.cells[OUT_MSB:0];
    end
    else
    begin
      dir = pins_clk.dir;
      en = !pins_clk.en_n && (func_view.mode != MODE_FLOAT);
      data = dir ? pins_clk.a : pins_clk.b;
    end
    if (dir)
    begin
      fn_d.b_out = data;
      fn_d.b_oe = en;
      fn_d.a_oe = 1'b0;
    end
    else
    begin
      fn_d.a_out = data;
      fn_d.a_oe = en;
      fn_d.b_oe = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fn_q <= '0;
    else
      fn_q <= fn_d;
  end

  assign a_out = fn_q.a_out;
  assign a_oe = fn_q.a_oe;
  assign b_out = fn_q.b_out;
  assign b_oe = fn_q.b_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  bypass_zero_a: assert property (
    @(posedge tck) disable iff (!rst_n)
    tap.capture_dr && !tap.reset && dec.dreg == DR_BYPASS |=> sc_q.bypass == 1'b0 ##0 sc_q.tdo == 1'b0)
    else $error("bypass stage did not capture zero");

  ir_capture_a: assert property (
    @(posedge tck) disable iff (!rst_n)
    tap.capture_ir && !tap.reset |=> sc_q.ir_shift == IR_CAPTURE && sc_q.tdo == 1'b1 && sc_q.tdo_oe)
    else $error("instruction capture value wrong");

  ir_reset_a: assert property (
    @(posedge tck) disable iff (!rst_n)
    tap.reset |=> sc_q.instr == IR_RESET && dec.dreg == DR_BYPASS && dec.mode == MODE_NORMAL)
    else $error("instruction not reset to bypass");

  sel_reset_a: assert property (
    @(posedge tck) disable iff (!rst_n)
    tap.reset |=> sc_q.sel == SEL_RESET && sc_q.sel_shift == SEL_RESET)
    else $error("selector not reset to signature");

  chain_keep_a: assert property (
    @(posedge tck) disable iff (!rst_n)
    tap.reset [*2] |=> $stable(sc_q.chain) && $stable(sc_q.shadow))
    else $error("chain changed in test reset");

  sel_capture_a: assert property (
    @(posedge tck) disable iff (!rst_n)
    tap.capture_dr && !tap.reset && dec.dreg == DR_SELECTOR |=> $stable(sc_q.sel_shift))
    else $error("selector changed on capture");

  shift_order_a: assert property (
    @(posedge tck) disable iff (!rst_n)
    tap.shift_dr && !tap.reset && dec.dreg == DR_CHAIN
      |=> sc_q.chain[CHAIN_W-1] == $past(tdi) && sc_q.tdo == $past(sc_q.chain[1]))
    else $error("chain shift order wrong");

  update_gate_a: assert property (
    @(posedge tck) disable iff (!rst_n)
    !tap.update_dr && !tap.reset |=> $stable(sc_q.sel))
    else $error("selector changed outside update");

  bit7_ignored_a: assert property (
    @(posedge tck) disable iff (!rst_n)
    decode_op(sc_q.instr) == decode_op({~sc_q.instr[7], sc_q.instr[6:0]}))
    else $error("opcode bit 7 changed the decode");

  float_outputs_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    func_view.mode == MODE_FLOAT |=> !a_oe && !b_oe)
    else $error("outputs driven in float mode");

endmodule
`default_nettype wire

//--- hw/sync_bits.sv
// Purpose: two-flop level synchroniser for a group of bits
// Assumes: each bit is a slow level; bits may land on different cycles
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module sync_bits
  import bscan_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } st_t;

  st_t st_q;
  st_t st_d;

  // shift the level through two stages
  always_comb
  begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign q = st_q.s2;

endmodule
`default_nettype wire

//--- hw/word_xfer.sv
// Purpose: carries a word from one clock domain to another
// Assumes: source word changes at most once per source period and the
//   destination clock is fast enough to see each toggle within that period
// Notes: held word is read across domains only after the toggle settles
`timescale 1ns/1ps
`default_nettype none
module word_xfer
  import bscan_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic src_clk,
  input wire logic dst_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] src_data,
  output logic [W-1:0] dst_data
);

  typedef struct packed {
    logic [W-1:0] held;
    logic tog;
  } src_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic seen;
    logic [W-1:0] word;
  } dst_t;

  src_t src_q;
  src_t src_d;
  dst_t dst_q;
  dst_t dst_d;

  // source: latch a changed word and flip the toggle
  always_comb
  begin
    src_d = src_q;
    if (src_data != src_q.held)
    begin
      src_d.held = src_data;
      src_d.tog = ~src_q.tog;
    end
  end

  always_ff @(posedge src_clk or negedge rst_n)
  begin
    if (!rst_n)
      src_q <= '0;
    else
      src_q <= src_d;
  end

  // destination: take the held word once the toggle has crossed
  always_comb
  begin
    dst_d = dst_q;
    dst_d.s1 = src_q.tog;
    dst_d.s2 = dst_q.s1;
    if (dst_q.s2 != dst_q.seen)
    begin
      dst_d.seen = dst_q.s2;
      dst_d.word = src_q.held;
    end
  end

  always_ff @(posedge dst_clk or negedge rst_n)
  begin
    if (!rst_n)
      dst_q <= '0;
    else
      dst_q <= dst_d;
  end

  assign dst_data = dst_q.word;

endmodule
`default_nettype wire

//--- include/bscan_pkg.sv
// Purpose: shared constants, carriers and opcode decode for the boundary-scan data registers
// Assumes: a separate test-port state machine supplies one-hot state flags on the test clock
// Notes: opcode bit 7 never reaches the decode
package bscan_pkg;

  // ----------------------------------------------------------------
  // widths and field positions
  // ----------------------------------------------------------------
  localparam int CHAIN_W = 18;
  localparam int IR_W = 8;
  localparam int SEL_W = 2;
  localparam int DIR_BIT = 17;
  localparam int EN_BIT = 16;
  localparam int IN_MSB = 15;
  localparam int IN_LSB = 8;
  localparam int OUT_MSB = 7;

  // ----------------------------------------------------------------
  // reset and capture values
  // ----------------------------------------------------------------
  localparam logic [7:0] IR_CAPTURE = 8'h81;
  localparam logic [7:0] IR_RESET = 8'hFF;
  localparam logic [1:0] SEL_RESET = 2'h2;

  // low seven opcode bits
  localparam logic [6:0] OP_CHAIN_TEST_A = 7'h00;
  localparam logic [6:0] OP_SAMPLE = 7'h02;
  localparam logic [6:0] OP_CHAIN_TEST_B = 7'h03;
  localparam logic [6:0] OP_OUTPUTS_FLOAT = 7'h06;
  localparam logic [6:0] OP_OUTPUTS_HOLD = 7'h07;
  localparam logic [6:0] OP_RUN_SELECTED_TEST = 7'h09;
  localparam logic [6:0] OP_READ_CHAIN_NORMAL = 7'h0A;
  localparam logic [6:0] OP_READ_CHAIN_TEST = 7'h0B;
  localparam logic [6:0] OP_CELL_SELF_CHECK = 7'h0C;
  localparam logic [6:0] OP_TOGGLE_OUTPUTS = 7'h0D;
  localparam logic [6:0] OP_SELECTOR_SCAN_NORMAL = 7'h0E;
  localparam logic [6:0] OP_SELECTOR_SCAN_TEST = 7'h0F;

  // selector codes
  localparam logic [1:0] SEL_SAMPLE_IN_TOGGLE_OUT = 2'h0;
  localparam logic [1:0] SEL_PATTERN_GENERATE = 2'h1;
  localparam logic [1:0] SEL_SIGNATURE_COMPRESS = 2'h2;
  localparam logic [1:0] SEL_BOTH_EIGHT = 2'h3;

  // feedback taps of the compression and pattern registers
  localparam logic [15:0] TAPS16 = 16'hB400;
  localparam logic [7:0] TAPS8 = 8'hB8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {DR_BYPASS, DR_CHAIN, DR_SELECTOR} dreg_t;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_TEST, MODE_FLOAT} mode_t;
  typedef enum logic [1:0] {CAP_KEEP, CAP_PINS, CAP_INVERT} cap_t;
  typedef enum logic [1:0] {RUN_NONE, RUN_SELECTED, RUN_TOGGLE} runop_t;

  typedef struct packed {
    dreg_t dreg;
    mode_t mode;
    cap_t cap;
    runop_t run;
  } decode_t;

  // one-hot state flags from the test-port state machine
  typedef struct packed {
    logic reset;
    logic idle;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;
  } tap_ctl_t;

  typedef struct packed {
    logic dir;
    logic en_n;
    logic [7:0] a;
    logic [7:0] b;
  } pins_t;

  // what the functional side needs from the test side
  typedef struct packed {
    mode_t mode;
    logic [CHAIN_W-1:0] cells;
  } xfer_t;

  // bit 7 never enters the case, so it cannot change the outcome
  function automatic decode_t decode_op(input logic [7:0] op);
    decode_t r;
    r = '{dreg: DR_BYPASS, mode: MODE_NORMAL, cap: CAP_KEEP, run: RUN_NONE};
    case (op[6:0])
      OP_CHAIN_TEST_A, OP_CHAIN_TEST_B: r = '{DR_CHAIN, MODE_TEST, CAP_PINS, RUN_NONE};
      OP_SAMPLE: r = '{DR_CHAIN, MODE_NORMAL, CAP_PINS, RUN_NONE};
      OP_OUTPUTS_FLOAT: r.mode = MODE_FLOAT;
      OP_OUTPUTS_HOLD: r.mode = MODE_TEST;
      OP_RUN_SELECTED_TEST: r = '{DR_BYPASS, MODE_TEST, CAP_KEEP, RUN_SELECTED};
      OP_READ_CHAIN_NORMAL: r = '{DR_CHAIN, MODE_NORMAL, CAP_KEEP, RUN_NONE};
      OP_READ_CHAIN_TEST: r = '{DR_CHAIN, MODE_TEST, CAP_KEEP, RUN_NONE};
      OP_CELL_SELF_CHECK: r = '{DR_CHAIN, MODE_NORMAL, CAP_INVERT, RUN_NONE};
      OP_TOGGLE_OUTPUTS: r = '{DR_BYPASS, MODE_TEST, CAP_KEEP, RUN_TOGGLE};
      OP_SELECTOR_SCAN_NORMAL: r.dreg = DR_SELECTOR;
      OP_SELECTOR_SCAN_TEST: r = '{DR_SELECTOR, MODE_TEST, CAP_KEEP, RUN_NONE};
      default: r.dreg = DR_BYPASS;
    endcase
    return r;
  endfunction

endpackage
